// [tb/btadj_host.sv]
// Host model that sends framed text commands to the trim handler and sinks its replies.
`timescale 1ns/1ps
module btadj_host (
	input wire logic mclk,
	input wire logic stallBit,
	output logic [7:0] rxData,
	output logic rxValid,
	output logic txReady
);
	// =====================================================================
	// Reply sink
	// Random stalls make the handler hold the pending character and leave gaps in the reply.
	assign txReady = stallBit;

	initial begin
		rxData = 8'h00;
		rxValid = 1'b0;
	end

	// =====================================================================
	// Command sender
	function automatic logic [7:0] crc8(input string s);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 0; i < s.len(); i++) begin
			c ^= s[i];
			for (int b = 0; b < 8; b++) begin
				c = c[7] ? ({c[6:0], 1'b0} ^ 8'h07) : {c[6:0], 1'b0};
			end
		end
		return c;
	endfunction

	// A set bad flag spoils the checksum by one so that the handler must refuse the frame.
	task automatic sendLine(input string body, input bit bad);
		string line;
		logic [7:0] crc;
		crc = crc8(body) + {7'h00, bad};
		line = $sformatf("%s%0d\015", body, crc);
		for (int i = 0; i < line.len(); i++) begin
			@(negedge mclk);
			rxData = line[i];
			rxValid = 1'b1;
		end
		@(negedge mclk);
		rxValid = 1'b0;
	endtask
endmodule

// [tb/tb_bias_trim_adjust_commands.sv]
// Self-checking bench for the trim command handler.
`timescale 1ns/1ps
module tb_bias_trim_adjust_commands;
	logic mclk;
	logic rst_b;
	logic stallBit = 1'b1;
	logic [7:0] rxData;
	logic rxValid;
	logic txReady;
	logic [7:0] txData;
	logic txValid;
	logic [8:0][31:0] trimOffset;
	logic [31:0] referenceWord;
	logic [31:0] rngState = 32'h0000f989;
	logic [31:0] refModel = 32'h00000000;
	int offModel[9] = '{default: 0};
	int numErrors = 0;
	int checksDone = 0;
	int replies = 0;
	string expQ[$];
	string got = "";

	btadj_cmd DUT (
		.mclk(mclk),
		.rst_b(rst_b),
		.rxData(rxData),
		.rxValid(rxValid),
		.txReady(txReady),
		.txData(txData),
		.txValid(txValid),
		.trimOffset(trimOffset),
		.referenceWord(referenceWord)
	);

	btadj_host host (
		.mclk(mclk),
		.stallBit(stallBit),
		.rxData(rxData),
		.rxValid(rxValid),
		.txReady(txReady)
	);

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	// =====================================================================
	// Helpers
	function automatic logic [31:0] nextRnd();
		rngState ^= rngState << 13;
		rngState ^= rngState >> 17;
		rngState ^= rngState << 5;
		return rngState;
	endfunction

	always @(negedge mclk) begin
		stallBit <= (nextRnd() % 32'h00000004) != 32'h00000000;
	end

	function automatic string fmtFix(input int v, input int frac);
		int a;
		int p;
		string fs;
		a = (v < 0) ? -v : v;
		p = 1;
		repeat (frac) p *= 10;
		fs = $sformatf("%0d", a % p);
		while (fs.len() < frac) fs = {"0", fs};
		return {(v < 0) ? "-" : "", $sformatf("%0d.", a / p), fs};
	endfunction

	function automatic string expTail(input string s);
		return {s, $sformatf("%0d", host.crc8(s))};
	endfunction

	task automatic checkStr(input string what, input string exp, input string seen);
		checksDone++;
		if (exp != seen) begin
			numErrors++;
			$display("[ERR] %s expected %s seen %s", what, exp, seen);
		end
	endtask

	task automatic checkVal(input string what, input logic [31:0] exp, input logic [31:0] seen);
		checksDone++;
		if (exp !== seen) begin
			numErrors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic completeRun();
		$display("checks %0d errors %0d", checksDone, numErrors);
		if (numErrors == 0 && checksDone > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// =====================================================================
	// Reply monitor
	always @(posedge mclk) begin
		if (rst_b === 1'b1 && txValid === 1'b1 && txReady === 1'b1) begin
			if (txData === btadj_pkg::CH_CR) begin
				if (expQ.size() == 0) begin
					checkStr("unexpected reply", "", got);
				end else begin
					checkStr("reply", expQ.pop_front(), got);
				end
				got = "";
				replies++;
			end else begin
				got = {got, $sformatf("%c", txData)};
			end
		end
	end

	// =====================================================================
	// Command drivers
	task automatic waitReply(input int prev);
		int n;
		n = 0;
		while (replies == prev && n < 20000) begin
			@(posedge mclk);
			n++;
		end
		if (replies == prev) begin
			numErrors++;
			$display("[ERR] reply wait expected CR seen timeout");
			completeRun();
		end
		@(negedge mclk);
	endtask

	task automatic checkAll();
		for (int i = 0; i < 9; i++) begin
			checkVal("trim offset", offModel[i], trimOffset[i]);
		end
		checkVal("reference word", refModel, referenceWord);
	endtask

	task automatic doRef(input logic [31:0] v, input bit bad);
		int prev;
		prev = replies;
		if (!bad) begin
			refModel = v;
		end
		expQ.push_back(expTail($sformatf("#srf,%0d,%0d,", bad, refModel)));
		host.sendLine($sformatf("$srf,%0d,", v), bad);
		waitReply(prev);
		checkAll();
	endtask

	task automatic doAdj(input bit bad);
		int prev;
		int d;
		int frac;
		string cmd;
		string rsp;
		prev = replies;
		cmd = "$sdbto,";
		rsp = $sformatf("#sdbto,%0d,", bad);
		for (int i = 0; i < 9; i++) begin
			frac = (i < 3) ? 5 : ((i < 6) ? 6 : 7);
			d = int'(nextRnd() % 32'h002dc6c0) - 1500000;
			cmd = {cmd, fmtFix(d, frac), ","};
			if (!bad) begin
				offModel[i] += d;
			end
			rsp = {rsp, fmtFix(offModel[i], frac), ","};
		end
		expQ.push_back(expTail(rsp));
		host.sendLine(cmd, bad);
		waitReply(prev);
		checkAll();
	endtask

	// =====================================================================
	// Main sequence
	initial begin
		rst_b = 1'b0;
		repeat (3) @(posedge mclk);
		@(negedge mclk);
		rst_b = 1'b1;
		checkAll();
		doRef(32'h0000aa76, 1'b0);
		doRef(nextRnd(), 1'b0);
		doRef(nextRnd(), 1'b1);
		doAdj(1'b0);
		doAdj(1'b0);
		doAdj(1'b1);
		doRef(32'hffffffff, 1'b0);
		// A name this handler does not own is dropped with no reply and no change.
		host.sendLine("$xrf,5,", 1'b0);
		repeat (100) @(negedge mclk);
		checkAll();
		// A reset in mid-run must drop every adjusted value back to zero.
		rst_b = 1'b0;
		repeat (3) @(negedge mclk);
		rst_b = 1'b1;
		offModel = '{default: 0};
		refModel = 32'h00000000;
		checkAll();
		doAdj(1'b0);
		completeRun();
	end
endmodule

// [verilog/btadj_cmd.sv]
// Text command handler that adjusts bias trim offsets and stores the reference word.
`timescale 1ns/1ps
// How it works
// - Adjust command adds each delta to offset.
// - Adjust reply: name, status, nine offsets, CRC.
// - Gyro offsets printed with five decimals.
// - Accelerometer offsets printed with six decimals.
// - Inclinometer offsets printed with seven decimals.
// - Reference command replaces stored reference word.
// - Reference reply: name, status, value, CRC.
// - Changed values last only until reset.
module btadj_cmd (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [7:0] rxData,
	input wire logic rxValid,
	input wire logic txReady,
	output logic [7:0] txData,
	output logic txValid,
	output logic [8:0][31:0] trimOffset,
	output logic [31:0] referenceWord
);
	typedef struct packed {
		btadj_pkg::btadj_state_t st;
		logic adjCmd;
		logic [39:0] name;
		logic [31:0] acc;
		logic neg;
		logic inFrac;
		logic [2:0] fracCnt;
		logic [3:0] idx;
		logic bad;
		logic ok;
		logic [7:0] crc;
		logic [8:0][31:0] delta;
		logic [8:0][31:0] offs;
		logic [31:0] refw;
		logic [3:0] vIdx;
		logic [1:0] sub;
		logic [3:0] hIdx;
		logic [7:0] txData;
		logic txValid;
	} btadj_main_t;

	btadj_main_t s_q;
	btadj_main_t s_d;
	logic canSend;
	logic [3:0] nVals;
	logic [3:0] hdrLen;
	logic [2:0] fracTgt;
	logic [31:0] dig;
	logic [31:0] mag;
	logic [39:0] nameShift;
	logic isCrc;
	logic [31:0] val;
	logic valNeg;
	logic emitGo;
	logic crcUpd;
	logic [7:0] emitCh;
	logic fmtLoad;
	logic fmtTake;
	logic [31:0] fmtValue;
	logic [2:0] fmtFrac;
	logic [7:0] fmtCh;
	logic fmtValid;
	logic fmtDone;

	function automatic logic [2:0] fracFor(input logic adj, input logic [3:0] i);
		if (!adj) begin
			return btadj_pkg::FRAC_NONE;
		end else if (i < btadj_pkg::ACCEL_FIRST) begin
			return btadj_pkg::FRAC_GYRO;
		end else if (i < btadj_pkg::INCL_FIRST) begin
			return btadj_pkg::FRAC_ACCEL;
		end
		return btadj_pkg::FRAC_INCL;
	endfunction

	btadj_dec_fmt uFmt (
		.mclk(mclk),
		.rst_b(rst_b),
		.load(fmtLoad),
		.value(fmtValue),
		.fracDigits(fmtFrac),
		.take(fmtTake),
		.ch(fmtCh),
		.chValid(fmtValid),
		.done(fmtDone)
	);

	// =====================================================================
	// Command parser, executor and reply sequencer
	// Incoming characters are ignored while a reply is being sent; the host waits for it.
	always_comb begin
		s_d = s_q;
		emitGo = 1'b0;
		crcUpd = 1'b0;
		emitCh = btadj_pkg::CH_CR;
		fmtLoad = 1'b0;
		fmtTake = 1'b0;
		fmtValue = 32'h0;
		fmtFrac = btadj_pkg::FRAC_NONE;
		canSend = !s_q.txValid || txReady;
		if (s_q.txValid && txReady) begin
			s_d.txValid = 1'b0;
		end
		nVals = s_q.adjCmd ? btadj_pkg::ADJ_VALUES : btadj_pkg::REF_VALUES;
		hdrLen = s_q.adjCmd ? btadj_pkg::LEN_ADJ : btadj_pkg::LEN_REF;
		fracTgt = fracFor(s_q.adjCmd, s_q.idx);
		dig = {24'h0, rxData - btadj_pkg::CH_ZERO};
		mag = s_q.acc * btadj_pkg::POW10[fracTgt - s_q.fracCnt];
		nameShift = s_q.name >> {hdrLen - s_q.hIdx, 3'b000};
		isCrc = (s_q.vIdx == nVals);
		val = isCrc ? {24'h0, s_q.crc} : (s_q.adjCmd ? s_q.offs[s_q.vIdx] : s_q.refw);
		valNeg = s_q.adjCmd && !isCrc && val[31];
		case (s_q.st)
			btadj_pkg::ST_IDLE: begin
				if (rxValid && rxData == btadj_pkg::CH_DOLLAR) begin
					s_d.st = btadj_pkg::ST_NAME;
					s_d.name = 40'h0;
					s_d.crc = btadj_pkg::crc8Step(btadj_pkg::CRC_INIT, rxData);
				end
			end
			btadj_pkg::ST_NAME: begin
				if (rxValid) begin
					s_d.crc = btadj_pkg::crc8Step(s_q.crc, rxData);
					s_d.acc = 32'h0;
					s_d.neg = 1'b0;
					s_d.inFrac = 1'b0;
					s_d.fracCnt = 3'h0;
					s_d.idx = 4'h0;
					s_d.bad = 1'b0;
					if (rxData != btadj_pkg::CH_COMMA) begin
						s_d.name = {s_q.name[31:0], rxData};
					end else if (s_q.name == btadj_pkg::NAME_ADJ) begin
						s_d.adjCmd = 1'b1;
						s_d.st = btadj_pkg::ST_PARM;
					end else if (s_q.name == btadj_pkg::NAME_REF) begin
						s_d.adjCmd = 1'b0;
						s_d.st = btadj_pkg::ST_PARM;
					end else begin
						s_d.st = btadj_pkg::ST_IDLE;
					end
				end
			end
			btadj_pkg::ST_PARM: begin
				if (rxValid) begin
					if (s_q.idx != nVals) begin
						s_d.crc = btadj_pkg::crc8Step(s_q.crc, rxData);
					end
					if (rxData == btadj_pkg::CH_CR) begin
						s_d.ok = (s_q.idx == nVals) && !s_q.bad && (s_q.acc[31:8] == 24'h0)
							&& (s_q.acc[7:0] == s_q.crc);
						s_d.st = btadj_pkg::ST_EXEC;
					end else if (rxData == btadj_pkg::CH_COMMA) begin
						if (s_q.idx == nVals) begin
							s_d.bad = 1'b1;
						end else begin
							s_d.delta[s_q.idx] = s_q.neg ? (32'h0 - mag) : mag;
							s_d.idx = s_q.idx + 4'h1;
							s_d.acc = 32'h0;
							s_d.neg = 1'b0;
							s_d.inFrac = 1'b0;
							s_d.fracCnt = 3'h0;
						end
					end else if (rxData == btadj_pkg::CH_MINUS && s_q.adjCmd) begin
						s_d.neg = 1'b1;
					end else if (rxData == btadj_pkg::CH_DOT && s_q.adjCmd) begin
						s_d.inFrac = 1'b1;
					end else if (rxData >= btadj_pkg::CH_ZERO && rxData <= btadj_pkg::CH_NINE) begin
						if (!s_q.inFrac || s_q.fracCnt < fracTgt) begin
							s_d.acc = (s_q.acc * btadj_pkg::TEN) + dig;
							s_d.fracCnt = s_q.fracCnt + {2'h0, s_q.inFrac};
						end
					end else begin
						s_d.bad = 1'b1;
					end
				end
			end
			btadj_pkg::ST_EXEC: begin
				if (s_q.ok && s_q.adjCmd) begin
					for (int i = 0; i < 9; i++) begin
						s_d.offs[i] = s_q.offs[i] + s_q.delta[i];
					end
				end else if (s_q.ok) begin
					s_d.refw = s_q.delta[0];
				end
				s_d.hIdx = 4'h0;
				s_d.st = btadj_pkg::ST_HDR;
			end
			btadj_pkg::ST_HDR: begin
				if (canSend) begin
					emitGo = 1'b1;
					crcUpd = 1'b1;
					s_d.hIdx = s_q.hIdx + 4'h1;
					if (s_q.hIdx == 4'h0) begin
						emitCh = btadj_pkg::CH_HASH;
						s_d.crc = btadj_pkg::CRC_INIT;
					end else if (s_q.hIdx <= hdrLen) begin
						emitCh = nameShift[7:0];
					end else if (s_q.hIdx == hdrLen + 4'h1) begin
						emitCh = btadj_pkg::CH_COMMA;
					end else begin
						emitCh = btadj_pkg::CH_ZERO + (s_q.ok ? btadj_pkg::STATUS_OK
							: btadj_pkg::STATUS_FAIL);
						s_d.vIdx = 4'h0;
						s_d.sub = 2'h0;
						s_d.st = btadj_pkg::ST_VAL;
					end
				end
			end
			btadj_pkg::ST_VAL: begin
				case (s_q.sub)
					2'h0: begin
						if (canSend) begin
							emitGo = 1'b1;
							crcUpd = 1'b1;
							emitCh = btadj_pkg::CH_COMMA;
							s_d.sub = 2'h1;
						end
					end
					2'h1: begin
						if (canSend || !valNeg) begin
							emitGo = valNeg;
							crcUpd = 1'b1;
							emitCh = btadj_pkg::CH_MINUS;
							fmtLoad = 1'b1;
							fmtValue = valNeg ? (32'h0 - val) : val;
							fmtFrac = isCrc ? btadj_pkg::FRAC_NONE : fracFor(s_q.adjCmd, s_q.vIdx);
							s_d.sub = 2'h2;
						end
					end
					default: begin
						if (fmtDone) begin
							s_d.sub = 2'h0;
							s_d.vIdx = s_q.vIdx + 4'h1;
							if (isCrc) begin
								s_d.st = btadj_pkg::ST_END;
							end
						end else if (fmtValid && canSend) begin
							emitGo = 1'b1;
							crcUpd = !isCrc;
							emitCh = fmtCh;
							fmtTake = 1'b1;
						end
					end
				endcase
			end
			btadj_pkg::ST_END: begin
				if (canSend) begin
					emitGo = 1'b1;
					s_d.st = btadj_pkg::ST_IDLE;
				end
			end
			default: begin
				s_d.st = btadj_pkg::ST_IDLE;
			end
		endcase
		if (emitGo) begin
			s_d.txData = emitCh;
			s_d.txValid = 1'b1;
			if (crcUpd && s_q.st != btadj_pkg::ST_HDR) begin
				s_d.crc = btadj_pkg::crc8Step(s_q.crc, emitCh);
			end else if (crcUpd && s_q.hIdx == 4'h0) begin
				s_d.crc = btadj_pkg::crc8Step(btadj_pkg::CRC_INIT, emitCh);
			end else if (crcUpd) begin
				s_d.crc = btadj_pkg::crc8Step(s_q.crc, emitCh);
			end
		end
	end

	// Reset brings back zero offsets; nothing here is kept across power or reset.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign txData = s_q.txData;
	assign txValid = s_q.txValid;
	assign trimOffset = s_q.offs;
	assign referenceWord = s_q.refw;

	// =====================================================================
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	sequence sExecDone;
		s_q.st == btadj_pkg::ST_EXEC;
	endsequence
	sequence sHashOut;
		s_q.txValid && s_q.txData == btadj_pkg::CH_HASH;
	endsequence

	a_adjust_adds: assert property ((s_q.st == btadj_pkg::ST_EXEC && s_q.ok && s_q.adjCmd) |=>
		(s_q.offs[8] == $past(s_q.offs[8]) + $past(s_q.delta[8])))
		else $error("offset not incremented by its delta");
	a_reply_start: assert property (sExecDone |-> ##2 sHashOut)
		else $error("reply did not open with the hash mark");
	a_gyro_decimals: assert property ((fmtLoad && s_q.adjCmd && s_q.vIdx < 4'h3) |->
		fmtFrac == 3'h5) else $error("gyro offset not given five decimals");
	a_accel_decimals: assert property ((fmtLoad && s_q.adjCmd && s_q.vIdx inside {[4'h3:4'h5]}) |->
		fmtFrac == 3'h6) else $error("accelerometer offset not given six decimals");
	a_incl_decimals: assert property ((fmtLoad && s_q.adjCmd && s_q.vIdx inside {[4'h6:4'h8]}) |->
		fmtFrac == 3'h7) else $error("inclinometer offset not given seven decimals");
	a_ref_store: assert property ((s_q.st == btadj_pkg::ST_EXEC && s_q.ok && !s_q.adjCmd) |=>
		(s_q.refw == $past(s_q.delta[0])) ##1 $stable(s_q.refw))
		else $error("reference word not replaced");
	a_ref_unsigned: assert property ((s_q.st == btadj_pkg::ST_VAL && !s_q.adjCmd) |->
		!(s_q.txValid && s_q.txData == btadj_pkg::CH_MINUS))
		else $error("reference reply carries a sign");
	a_values_hold: assert property (!(s_q.st == btadj_pkg::ST_EXEC && s_q.ok) |=>
		($stable(s_q.offs) && $stable(s_q.refw))) else $error("values changed without a good command");
	a_crc_fail: assert property ((s_q.st == btadj_pkg::ST_HDR && !s_q.ok && canSend
		&& s_q.hIdx == hdrLen + 4'h2) |=> (s_q.txData == 8'h31))
		else $error("failed command not reported as failure");
endmodule

// [verilog/btadj_dec_fmt.sv]
// Serial unsigned binary to fixed-point decimal text converter.
`timescale 1ns/1ps
module btadj_dec_fmt (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic load,
	input wire logic [31:0] value,
	input wire logic [2:0] fracDigits,
	input wire logic take,
	output logic [7:0] ch,
	output logic chValid,
	output logic done
);
	typedef struct packed {
		logic [31:0] rem;
		logic [3:0] pos;
		logic [2:0] frac;
		logic started;
		logic pointDone;
		logic active;
	} btadj_fmt_t;

	btadj_fmt_t r_q;
	btadj_fmt_t r_d;
	logic [31:0] pw;
	logic [9:1] ge;
	logic [3:0] digit;
	logic pointNow;
	logic show;

	// =====================================================================
	// Digit extraction
	// Comparing against every multiple of the current power avoids a divider.
	assign pw = btadj_pkg::POW10[r_q.pos];
	genvar k;
	generate
		for (k = 1; k <= 9; k++) begin : gDigit
			assign ge[k] = {4'h0, r_q.rem} >= (36'(k) * {4'h0, pw});
		end
	endgenerate

	always_comb begin
		digit = 4'h0;
		for (int i = 1; i <= 9; i++) begin
			digit = digit + {3'h0, ge[i]};
		end
		pointNow = r_q.active && (r_q.frac != 3'h0) && !r_q.pointDone
			&& (r_q.pos == ({1'b0, r_q.frac} - 4'h1));
		show = r_q.started || (digit != 4'h0) || (r_q.pos <= {1'b0, r_q.frac});
		chValid = r_q.active && (pointNow || show);
		ch = pointNow ? btadj_pkg::CH_DOT : (btadj_pkg::CH_ZERO + {4'h0, digit});
		done = !r_q.active;
		r_d = r_q;
		if (load) begin
			r_d.rem = value;
			r_d.pos = btadj_pkg::FMT_TOP_POS;
			r_d.frac = fracDigits;
			r_d.started = 1'b0;
			r_d.pointDone = 1'b0;
			r_d.active = 1'b1;
		end else if (r_q.active) begin
			if (pointNow) begin
				r_d.pointDone = take;
			end else if (show) begin
				if (take) begin
					r_d.rem = r_q.rem - ({28'h0, digit} * pw);
					r_d.started = 1'b1;
					if (r_q.pos == 4'h0) begin
						r_d.active = 1'b0;
					end else begin
						r_d.pos = r_q.pos - 4'h1;
					end
				end
			end else begin
				r_d.pos = r_q.pos - 4'h1;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			r_q <= '0;
		end else begin
			r_q <= r_d;
		end
	end
endmodule

// [verilog/btadj_pkg.sv]
// Constants, state encoding and the CRC-8 step shared by the trim command handler.
package btadj_pkg;
	// =====================================================================
	// Character codes of the text protocol
	localparam logic [7:0] CH_DOLLAR = 8'h24;
	localparam logic [7:0] CH_HASH = 8'h23;
	localparam logic [7:0] CH_COMMA = 8'h2c;
	localparam logic [7:0] CH_CR = 8'h0d;
	localparam logic [7:0] CH_MINUS = 8'h2d;
	localparam logic [7:0] CH_DOT = 8'h2e;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [7:0] CH_NINE = 8'h39;

	// =====================================================================
	// Command names, right aligned as the name shifter holds them
	localparam logic [39:0] NAME_ADJ = 40'h736462746f;
	localparam logic [39:0] NAME_REF = 40'h0000737266;
	localparam logic [3:0] LEN_ADJ = 4'h5;
	localparam logic [3:0] LEN_REF = 4'h3;
	localparam logic [3:0] ADJ_VALUES = 4'h9;
	localparam logic [3:0] REF_VALUES = 4'h1;
	localparam logic [3:0] ACCEL_FIRST = 4'h3;
	localparam logic [3:0] INCL_FIRST = 4'h6;

	// =====================================================================
	// Number formats and status codes
	localparam logic [2:0] FRAC_GYRO = 3'h5;
	localparam logic [2:0] FRAC_ACCEL = 3'h6;
	localparam logic [2:0] FRAC_INCL = 3'h7;
	localparam logic [2:0] FRAC_NONE = 3'h0;
	localparam logic [7:0] STATUS_OK = 8'h00;
	localparam logic [7:0] STATUS_FAIL = 8'h01;
	localparam logic [3:0] FMT_TOP_POS = 4'h9;
	localparam logic [9:0][31:0] POW10 = {32'h3b9aca00, 32'h05f5e100, 32'h00989680,
		32'h000f4240, 32'h000186a0, 32'h00002710, 32'h000003e8, 32'h00000064,
		32'h0000000a, 32'h00000001};
	localparam logic [31:0] TEN = 32'h0000000a;

	// =====================================================================
	// CRC-8 generator, MSB first
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [7:0] CRC_INIT = 8'h00;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_NAME = 3'b001,
		ST_PARM = 3'b011,
		ST_EXEC = 3'b010,
		ST_HDR = 3'b110,
		ST_VAL = 3'b111,
		ST_END = 3'b101
	} btadj_state_t;

	function automatic logic [7:0] crc8Step(input logic [7:0] crc, input logic [7:0] data);
		logic [7:0] c;
		c = crc ^ data;
		for (int i = 0; i < 8; i++) begin
			c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
		end
		return c;
	endfunction
endpackage
